// [core/crypto_map_cfg.svh]
// crypto_map_cfg.svh: addresses, sizes and reset values of the engine operand window
// assumes byte addresses on a 16-bit DMA address bus
`ifndef CRYPTO_MAP_CFG_SVH
`define CRYPTO_MAP_CFG_SVH

// ==========================================================
// window bounds
`define CRY_WIN_LO      16'h7800
`define CRY_WIN_HI      16'h7FFF

// ==========================================================
// modular exponentiation operands
`define MX_BASE         16'h7800
`define MX_EXP_LO       16'h7800
`define MX_EXP_HI       16'h787F
`define MX_DAT_LO       16'h7880
`define MX_DAT_HI       16'h78FF
`define MX_MOD_LO       16'h7900
`define MX_MOD_HI       16'h797F
`define MX_DEPTH        384

// ==========================================================
// hash operands
`define HS_BASE         16'h7A00
`define HS_DIN_LO       16'h7A00
`define HS_DIN_HI       16'h7A3F
`define HS_IV_LO        16'h7A40
`define HS_IV_HI        16'h7A53
`define HS_LIN_LO       16'h7A54
`define HS_LIN_HI       16'h7A5B
`define HS_DIG_LO       16'h7A70
`define HS_DIG_HI       16'h7A83
`define HS_LOUT_LO      16'h7A84
`define HS_LOUT_HI      16'h7A8B
`define HS_DEPTH        140

// ==========================================================
// block cipher operands
`define AE_BASE         16'h7C00
`define AE_KEY_LO       16'h7C00
`define AE_KEY_HI       16'h7C1F
`define AE_TXA_LO       16'h7C20
`define AE_TXA_HI       16'h7C2F
`define AE_TXB_LO       16'h7C30
`define AE_TXB_HI       16'h7C3F
`define AE_XOR_LO       16'h7C40
`define AE_XOR_HI       16'h7C4F
`define AE_DEPTH        80

// ==========================================================
// reset values
`define RST_BYTE        8'h00

`endif

// [core/crypto_map_pkg.sv]
// crypto_map_pkg.sv: types shared by the operand window modules
// assumes crypto_map_cfg.svh holds the numbers
`default_nettype none

package crypto_map_pkg;

   // ==========================================================
   // decoded operand region, one-hot
   typedef enum logic [12:0] {
      rg_none = 13'h0001,
      rg_exp  = 13'h0002,
      rg_dat  = 13'h0004,
      rg_mod  = 13'h0008,
      rg_din  = 13'h0010,
      rg_iv   = 13'h0020,
      rg_lin  = 13'h0040,
      rg_dig  = 13'h0080,
      rg_lout = 13'h0100,
      rg_key  = 13'h0200,
      rg_txa  = 13'h0400,
      rg_txb  = 13'h0800,
      rg_xor  = 13'h1000
   } region_type;

   typedef logic [7:0] byte_type;

endpackage : crypto_map_pkg

`default_nettype wire

// [core/crypto_operand_map.sv]
// crypto_operand_map.sv: address decode and operand storage of the security engines
// assumes dma and host requests come from logic on sys_clk, engines use their own ports
`timescale 1ns/100ps
`default_nettype none

module crypto_operand_map
   import crypto_map_pkg::*;
#(
   parameter int MX_DEPTH = 384,
   parameter int HS_DEPTH = 140,
   parameter int AE_DEPTH = 80
)(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // dma side
   input  wire logic        dma_req,
   input  wire logic        dma_we,
   input  wire logic [15:0] dma_addr,
   input  wire logic [7:0]  dma_wdata,
   output var  logic [7:0]  dma_rdata,
   output var  logic        dma_rvalid,
   // host side
   input  wire logic        host_req,
   input  wire logic        host_we,
   input  wire logic [15:0] host_addr,
   input  wire logic [7:0]  host_wdata,
   output var  logic        host_blocked,
   output var  logic        sram_req,
   output var  logic        sram_we,
   output var  logic [15:0] sram_addr,
   output var  logic [7:0]  sram_wdata,
   // modular exponentiation engine port
   input  wire logic        mx_eng_en,
   input  wire logic        mx_eng_we,
   input  wire logic [8:0]  mx_eng_addr,
   input  wire logic [7:0]  mx_eng_wdata,
   output var  logic [7:0]  mx_eng_rdata,
   // hash engine port
   input  wire logic        hs_eng_en,
   input  wire logic        hs_eng_we,
   input  wire logic [7:0]  hs_eng_addr,
   input  wire logic [7:0]  hs_eng_wdata,
   output var  logic [7:0]  hs_eng_rdata,
   // block cipher engine port
   input  wire logic        ae_eng_en,
   input  wire logic        ae_eng_we,
   input  wire logic [6:0]  ae_eng_addr,
   input  wire logic [7:0]  ae_eng_wdata,
   output var  logic [7:0]  ae_eng_rdata
);
`include "crypto_map_cfg.svh"

   // ==========================================================
   // decode functions

   // map a byte address to its operand region
   function automatic region_type decode_region(input logic [15:0] a);
      region_type r;
      r = rg_none;
      if (a >= `MX_EXP_LO && a <= `MX_EXP_HI)
         r = rg_exp;
      else if (a >= `MX_DAT_LO && a <= `MX_DAT_HI)
         r = rg_dat;
      else if (a >= `MX_MOD_LO && a <= `MX_MOD_HI)
         r = rg_mod;
      else if (a >= `HS_DIN_LO && a <= `HS_DIN_HI)
         r = rg_din;
      else if (a >= `HS_IV_LO && a <= `HS_IV_HI)
         r = rg_iv;
      else if (a >= `HS_LIN_LO && a <= `HS_LIN_HI)
         r = rg_lin;
      else if (a >= `HS_DIG_LO && a <= `HS_DIG_HI)
         r = rg_dig;
      else if (a >= `HS_LOUT_LO && a <= `HS_LOUT_HI)
         r = rg_lout;
      else if (a >= `AE_KEY_LO && a <= `AE_KEY_HI)
         r = rg_key;
      else if (a >= `AE_TXA_LO && a <= `AE_TXA_HI)
         r = rg_txa;
      else if (a >= `AE_TXB_LO && a <= `AE_TXB_HI)
         r = rg_txb;
      else if (a >= `AE_XOR_LO && a <= `AE_XOR_HI)
         r = rg_xor;
      return r;
   endfunction : decode_region

   // regions filled only by the engine refuse dma writes
   function automatic logic dma_writable(input region_type r);
      return !(r == rg_none || r == rg_dig || r == rg_lout || r == rg_xor);
   endfunction : dma_writable

   // whole engine window, used for host filtering
   function automatic logic in_window(input logic [15:0] a);
      return (a >= `CRY_WIN_LO) && (a <= `CRY_WIN_HI);
   endfunction : in_window

   // ==========================================================
   // memory ports, one pair per engine
   ram_port_if #(.AW(9)) mx_dma ();
   ram_port_if #(.AW(9)) mx_eng ();
   ram_port_if #(.AW(8)) hs_dma ();
   ram_port_if #(.AW(8)) hs_eng ();
   ram_port_if #(.AW(7)) ae_dma ();
   ram_port_if #(.AW(7)) ae_eng ();

   region_type  dma_reg;
   logic        dma_wr_ok;
   logic        mx_sel;
   logic        hs_sel;
   logic        ae_sel;
   logic [15:0] mx_off;
   logic [15:0] hs_off;
   logic [15:0] ae_off;

   // decode of the current dma request
   always_comb
   begin
      dma_reg   = decode_region(dma_addr);
      dma_wr_ok = dma_writable(dma_reg);
      mx_sel    = (dma_reg == rg_exp) || (dma_reg == rg_dat) || (dma_reg == rg_mod);
      hs_sel    = (dma_reg == rg_din) || (dma_reg == rg_iv) || (dma_reg == rg_lin)
                  || (dma_reg == rg_dig) || (dma_reg == rg_lout);
      ae_sel    = (dma_reg == rg_key) || (dma_reg == rg_txa) || (dma_reg == rg_txb)
                  || (dma_reg == rg_xor);
      mx_off    = dma_addr - `MX_BASE;
      hs_off    = dma_addr - `HS_BASE;
      ae_off    = dma_addr - `AE_BASE;
   end

   // dma requests drive port a of the engine memories; host requests never reach them
   assign mx_dma.en    = dma_req && mx_sel;
   assign hs_dma.en    = dma_req && hs_sel;
   assign ae_dma.en    = dma_req && ae_sel;
   assign mx_dma.we    = dma_we && dma_wr_ok;
   assign hs_dma.we    = dma_we && dma_wr_ok;
   assign ae_dma.we    = dma_we && dma_wr_ok;
   assign mx_dma.addr  = mx_off[8:0];
   assign hs_dma.addr  = hs_off[7:0];
   assign ae_dma.addr  = ae_off[6:0];
   assign mx_dma.wdata = dma_wdata;
   assign hs_dma.wdata = dma_wdata;
   assign ae_dma.wdata = dma_wdata;

   // engine side ports pass straight to the memories
   assign mx_eng.en    = mx_eng_en;
   assign mx_eng.we    = mx_eng_we;
   assign mx_eng.addr  = mx_eng_addr;
   assign mx_eng.wdata = mx_eng_wdata;
   assign hs_eng.en    = hs_eng_en;
   assign hs_eng.we    = hs_eng_we;
   assign hs_eng.addr  = hs_eng_addr;
   assign hs_eng.wdata = hs_eng_wdata;
   assign ae_eng.en    = ae_eng_en;
   assign ae_eng.we    = ae_eng_we;
   assign ae_eng.addr  = ae_eng_addr;
   assign ae_eng.wdata = ae_eng_wdata;

   // ==========================================================
   // engine memories
   // one memory per engine, shared by the dma port and the engine port
   operand_ram #(.DEPTH(MX_DEPTH), .AW(9)) u_mx_ram (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pa      (mx_dma),
      .pb      (mx_eng)
   );

   operand_ram #(.DEPTH(HS_DEPTH), .AW(8)) u_hs_ram (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pa      (hs_dma),
      .pb      (hs_eng)
   );

   operand_ram #(.DEPTH(AE_DEPTH), .AW(7)) u_ae_ram (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pa      (ae_dma),
      .pb      (ae_eng)
   );

   assign mx_eng_rdata = mx_eng.rdata;
   assign hs_eng_rdata = hs_eng.rdata;
   assign ae_eng_rdata = ae_eng.rdata;

   // ==========================================================
   // dma read return path
   logic       rd_pend_ff;
   logic       nxt_rd_pend;
   logic [2:0] rd_src_ff;      // one-hot engine of the pending read, zero for a gap
   logic [2:0] nxt_rd_src;
   logic [7:0] dma_rdata_ff;
   logic [7:0] nxt_dma_rdata;
   logic       dma_rvalid_ff;
   logic       nxt_dma_rvalid;

   // next values of the read pipeline
   always_comb
   begin
      nxt_rd_pend    = dma_req && !dma_we;
      nxt_rd_src     = {ae_sel, hs_sel, mx_sel};
      nxt_dma_rvalid = rd_pend_ff;
      nxt_dma_rdata  = dma_rdata_ff;
      if (rd_pend_ff)
      begin
         // operand byte of the engine in rd_src_ff read back through dma, zero for a gap
         if (rd_src_ff[0])
            nxt_dma_rdata = mx_dma.rdata;
         else if (rd_src_ff[1])
            nxt_dma_rdata = hs_dma.rdata;
         else if (rd_src_ff[2])
            nxt_dma_rdata = ae_dma.rdata;
         else
            nxt_dma_rdata = `RST_BYTE;
      end
   end

   // read pipeline registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_pend_ff    <= 1'b0;
         rd_src_ff     <= 3'h0;
         dma_rdata_ff  <= `RST_BYTE;
         dma_rvalid_ff <= 1'b0;
      end
      else
      begin
         rd_pend_ff    <= nxt_rd_pend;
         rd_src_ff     <= nxt_rd_src;
         dma_rdata_ff  <= nxt_dma_rdata;
         dma_rvalid_ff <= nxt_dma_rvalid;
      end
   end

   assign dma_rdata  = dma_rdata_ff;
   assign dma_rvalid = dma_rvalid_ff;

   // ==========================================================
   // host access filter
   logic        host_blocked_ff;
   logic        nxt_host_blocked;
   logic        sram_req_ff;
   logic        nxt_sram_req;
   logic        sram_we_ff;
   logic        nxt_sram_we;
   logic [15:0] sram_addr_ff;
   logic [15:0] nxt_sram_addr;
   logic [7:0]  sram_wdata_ff;
   logic [7:0]  nxt_sram_wdata;

   // forward host traffic outside the window, flag the rest
   always_comb
   begin
      nxt_host_blocked = 1'b0;
      nxt_sram_req     = 1'b0;
      nxt_sram_we      = sram_we_ff;
      nxt_sram_addr    = sram_addr_ff;
      nxt_sram_wdata   = sram_wdata_ff;
      if (host_req)
      begin
         if (in_window(host_addr))
            nxt_host_blocked = 1'b1;
         else
         begin
            nxt_sram_req   = 1'b1;
            nxt_sram_we    = host_we;
            nxt_sram_addr  = host_addr;
            nxt_sram_wdata = host_wdata;
         end
      end
   end

   // host filter registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         host_blocked_ff <= 1'b0;
         sram_req_ff     <= 1'b0;
         sram_we_ff      <= 1'b0;
         sram_addr_ff    <= 16'h0000;
         sram_wdata_ff   <= `RST_BYTE;
      end
      else
      begin
         host_blocked_ff <= nxt_host_blocked;
         sram_req_ff     <= nxt_sram_req;
         sram_we_ff      <= nxt_sram_we;
         sram_addr_ff    <= nxt_sram_addr;
         sram_wdata_ff   <= nxt_sram_wdata;
      end
   end

   assign host_blocked = host_blocked_ff;
   assign sram_req     = sram_req_ff;
   assign sram_we      = sram_we_ff;
   assign sram_addr    = sram_addr_ff;
   assign sram_wdata   = sram_wdata_ff;

endmodule : crypto_operand_map

`default_nettype wire

// [core/operand_ram.sv]
// operand_ram.sv: two-port byte memory serving one engine and the dma side
// assumes one clock; port b is the engine, port a the dma side
`timescale 1ns/100ps
`default_nettype none

module operand_ram
   import crypto_map_pkg::*;
#(
   parameter int DEPTH = 384,
   parameter int AW    = 9
)(
   input  wire logic  sys_clk,
   input  wire logic  rst,
   ram_port_if.mem    pa,
   ram_port_if.mem    pb
);
`include "crypto_map_cfg.svh"

   byte_type mem_q [DEPTH];
   byte_type a_rd_ff;
   byte_type b_rd_ff;
   byte_type nxt_a_rd;
   byte_type nxt_b_rd;

   // ==========================================================
   // read data, zero beyond depth
   always_comb
   begin
      nxt_a_rd = a_rd_ff;
      nxt_b_rd = b_rd_ff;
      if (pa.en && !pa.we)
         nxt_a_rd = (int'(pa.addr) < DEPTH) ? mem_q[pa.addr] : `RST_BYTE;
      if (pb.en && !pb.we)
         nxt_b_rd = (int'(pb.addr) < DEPTH) ? mem_q[pb.addr] : `RST_BYTE;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         a_rd_ff <= `RST_BYTE;
         b_rd_ff <= `RST_BYTE;
      end
      else
      begin
         a_rd_ff <= nxt_a_rd;
         b_rd_ff <= nxt_b_rd;
      end
   end

   // storage; engine write lands last and wins a same-address clash
   always_ff @(posedge sys_clk)
   begin
      if (pa.en && pa.we && int'(pa.addr) < DEPTH)
         mem_q[pa.addr] <= pa.wdata;
      if (pb.en && pb.we && int'(pb.addr) < DEPTH)
         mem_q[pb.addr] <= pb.wdata;
   end

   assign pa.rdata = a_rd_ff;
   assign pb.rdata = b_rd_ff;

endmodule : operand_ram

`default_nettype wire

// [core/ram_port_if.sv]
// ram_port_if.sv: one byte-wide port of an engine operand memory
// assumes the memory registers its read data
`timescale 1ns/100ps
`default_nettype none

interface ram_port_if #(parameter int AW = 9) ();
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [7:0]    wdata;
   logic [7:0]    rdata;

   modport ctrl (output en, output we, output addr, output wdata, input rdata);
   modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface : ram_port_if

`default_nettype wire

// [verification/crypto_operand_map_chk.sv]
// crypto_operand_map_chk.sv: port assertions of the operand window
// assumes binding into crypto_operand_map, one clock domain
`timescale 1ns/100ps
`default_nettype none

module crypto_operand_map_chk
#(
   parameter int AE_DEPTH = 80
)(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        dma_req,
   input wire logic        dma_we,
   input wire logic [15:0] dma_addr,
   input wire logic [7:0]  dma_rdata,
   input wire logic        dma_rvalid,
   input wire logic        host_req,
   input wire logic        host_we,
   input wire logic [15:0] host_addr,
   input wire logic [7:0]  host_wdata,
   input wire logic        host_blocked,
   input wire logic        sram_req,
   input wire logic        sram_we,
   input wire logic [15:0] sram_addr,
   input wire logic [7:0]  sram_wdata,
   input wire logic        ae_eng_en,
   input wire logic        ae_eng_we,
   input wire logic [6:0]  ae_eng_addr,
   input wire logic [7:0]  ae_eng_rdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ==========================================================
   // decode helpers
   wire logic in_gap = dma_addr >= 16'h7800 && !(dma_addr inside
      {[16'h7800:16'h797F], [16'h7A00:16'h7A5B], [16'h7A70:16'h7A8B], [16'h7C00:16'h7C4F]});
   wire logic host_win = host_addr[15:11] == 5'h0F;

   sequence s_rd;
      dma_req && !dma_we;
   endsequence
   sequence s_gap_rd;
      s_rd ##0 in_gap;
   endsequence

   // ==========================================================
   // assertions
   chk_rd_answer:
   assert property (s_rd |-> ##2 dma_rvalid) else $error("read not answered after two cycles");
   chk_rv_cause:
   assert property (dma_rvalid |-> $past(dma_req && !dma_we, 2)) else $error("read answer without read");
   chk_gap_zero:
   assert property (s_gap_rd |-> ##2 (dma_rvalid && dma_rdata == 8'h00)) else $error("gap read not zero");
   chk_rdata_hold:
   assert property (!dma_rvalid |-> $stable(dma_rdata)) else $error("read data moved without answer");
   chk_host_block:
   assert property (host_req && host_win |=> host_blocked && !sram_req) else $error("host reached window");
   chk_host_fwd:
   assert property (host_req && !host_win |=> sram_req && !host_blocked && sram_addr == $past(host_addr)
      && sram_we == $past(host_we) && sram_wdata == $past(host_wdata)) else $error("host access not forwarded");
   chk_host_cause:
   assert property (host_blocked || sram_req |-> $past(host_req)) else $error("host pulse without request");
   chk_eng_oob:
   assert property (ae_eng_en && !ae_eng_we && ae_eng_addr >= AE_DEPTH |=> ae_eng_rdata == 8'h00)
      else $error("engine read past depth not zero");
endmodule : crypto_operand_map_chk

bind crypto_operand_map crypto_operand_map_chk #(.AE_DEPTH(AE_DEPTH)) i_chk (.*);

`default_nettype wire

// [verification/crypto_operand_map_tb_top.sv]
// crypto_operand_map_tb_top.sv: self-checking bench of the operand window
// assumes dma_model drives the dma side, the bench drives host and engines
`timescale 1ns/100ps
`default_nettype none

module crypto_operand_map_tb_top
   import crypto_map_pkg::*;
;
   logic        sys_clk, rst, dma_req, dma_we, dma_rvalid, host_req, host_we, host_blocked, sram_req, sram_we;
   logic [15:0] dma_addr, host_addr, sram_addr;
   logic [7:0]  dma_wdata, dma_rdata, host_wdata, sram_wdata;
   logic        mx_eng_en, mx_eng_we, hs_eng_en, hs_eng_we, ae_eng_en, ae_eng_we;
   logic [8:0]  mx_eng_addr;
   logic [7:0]  hs_eng_addr, mx_eng_wdata, mx_eng_rdata, hs_eng_wdata, hs_eng_rdata, ae_eng_wdata, ae_eng_rdata;
   logic [6:0]  ae_eng_addr;
   int          n_fail = 0, samples_checked = 0, cycles = 0;
   byte_type    q;
   localparam logic [15:0] MAP [18] = '{16'h7800, 16'h787F, 16'h7880, 16'h78FF, 16'h7900, 16'h797F,
      16'h7A00, 16'h7A3F, 16'h7A40, 16'h7A53, 16'h7A54, 16'h7A5B, 16'h7C00, 16'h7C1F, 16'h7C20,
      16'h7C2F, 16'h7C30, 16'h7C3F};
   localparam logic [15:0] GAP [8] = '{16'h7980, 16'h79FF, 16'h7A5C, 16'h7A6F, 16'h7A8C, 16'h7BFF,
      16'h7C50, 16'h7FFF};
   localparam logic [15:0] RO [6] = '{16'h7A70, 16'h7A83, 16'h7A84, 16'h7A8B, 16'h7C40, 16'h7C4F};

   crypto_operand_map #(.MX_DEPTH(384), .HS_DEPTH(140), .AE_DEPTH(80)) i_dut (.*);
   dma_model i_dma (.*);

   // clock, 5 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // one engine port access: 0 exponentiation, 1 hash, 2 cipher
   task automatic eng(input int e, input logic we, input logic [8:0] a, input byte_type d, output byte_type r);
      @(negedge sys_clk);
      {mx_eng_en, hs_eng_en, ae_eng_en} = 3'b100 >> e;
      {mx_eng_we, hs_eng_we, ae_eng_we} = {3{we}};
      {mx_eng_addr, hs_eng_addr, ae_eng_addr} = {a, a[7:0], a[6:0]};
      {mx_eng_wdata, hs_eng_wdata, ae_eng_wdata} = {3{d}};
      @(negedge sys_clk);
      {mx_eng_en, hs_eng_en, ae_eng_en} = 3'b000;
      r = (e == 0) ? mx_eng_rdata : (e == 1) ? hs_eng_rdata : ae_eng_rdata;
   endtask : eng

   function automatic int eidx(logic [15:0] a);
      return (a[11:8] >= 4'hC) ? 2 : (a[11:8] >= 4'hA) ? 1 : 0;
   endfunction : eidx

   function automatic logic [8:0] eoff(logic [15:0] a);
      return 9'(a - 16'h7800 - 16'(eidx(a)) * 16'h0200);
   endfunction : eoff

   // ==========================================================
   // range decode
   task automatic t_map;
      foreach (MAP[i]) i_dma.wr(MAP[i], 8'h40 + 8'(i));
      foreach (GAP[i]) i_dma.wr(GAP[i], 8'hFF);
      foreach (GAP[i])
      begin
         i_dma.rd(GAP[i], q);
         check("gap read", 16'(q), 16'h0000);
      end
      foreach (MAP[i])
      begin
         i_dma.rd(MAP[i], q);
         check("operand byte", 16'(q), 16'h0040 + 16'(i));
         eng(eidx(MAP[i]), 1'b0, eoff(MAP[i]), 8'h00, q);
         check("engine side byte", 16'(q), 16'h0040 + 16'(i));
      end
   endtask : t_map

   task automatic t_ro;
      foreach (RO[i])
      begin
         eng(eidx(RO[i]), 1'b1, eoff(RO[i]), 8'hC0 + 8'(i), q);
         i_dma.wr(RO[i], 8'h3C);
         i_dma.rd(RO[i], q);
         check("engine output byte", 16'(q), 16'h00C0 + 16'(i));
      end
      for (int e = 0; e < 3; e++)
      begin
         eng(e, 1'b0, (e == 0) ? 9'd384 : (e == 1) ? 9'd140 : 9'd80, 8'h00, q);
         check("engine past depth", 16'(q), 16'h0000);
      end
   endtask : t_ro

   task automatic t_host;
      logic [15:0] ha [6] = '{16'h0100, 16'h77FF, 16'h7800, 16'h7C20, 16'h7FFF, 16'h8000};
      logic        blk;
      for (int i = 0; i < 6; i++)
      begin
         @(negedge sys_clk);
         {host_req, host_we, host_addr, host_wdata} = {1'b1, i[0], ha[i], 8'hE0 + 8'(i)};
         blk = ha[i][15:11] == 5'h0F;
         @(negedge sys_clk);
         host_req = 1'b0;
         check("host_blocked", 16'(host_blocked), 16'(blk));
         check("sram_req", 16'(sram_req), 16'(!blk));
         if (!blk)
         begin
            check("sram_addr", sram_addr, ha[i]);
            check("sram_wdata", 16'(sram_wdata), 16'h00E0 + 16'(i));
            check("sram_we", 16'(sram_we), 16'(i[0]));
         end
      end
      i_dma.rd(16'h7C20, q);
      check("byte after host write", 16'(q), 16'h004E);
   endtask : t_host

   task automatic t_copy;
      for (int i = 0; i < 4; i++) i_dma.buf_mem[i] = 8'(8'h11 * (i + 1));
      i_dma.copy_in(8'h00, 16'h7C30, 4, 1);
      i_dma.copy_out(16'h7C30, 8'h10, 4);
      for (int i = 0; i < 4; i++)
         check("copied back byte", 16'(i_dma.buf_mem[16 + i]), 16'(8'h11 * (i + 1)));
   endtask : t_copy

   // ==========================================================
   // hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         complete_run();
      end
   end

   // main sequence
   initial
   begin
      rst = 1'b1;
      {host_req, host_we, host_addr, host_wdata} = '0;
      {mx_eng_en, mx_eng_we, mx_eng_addr, mx_eng_wdata, hs_eng_en, hs_eng_we, hs_eng_addr} = '0;
      {hs_eng_wdata, ae_eng_en, ae_eng_we, ae_eng_addr, ae_eng_wdata} = '0;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      t_map();
      t_ro();
      t_host();
      t_copy();
      complete_run();
   end
endmodule : crypto_operand_map_tb_top

`default_nettype wire

// [verification/dma_model.sv]
// dma_model.sv: behavioural dma controller with its own staging buffer
// assumes the window answers a read two cycles after the request edge
`timescale 1ns/100ps
`default_nettype none

module dma_model
   import crypto_map_pkg::*;
(
   input  wire logic        sys_clk,
   output var  logic        dma_req,
   output var  logic        dma_we,
   output var  logic [15:0] dma_addr,
   output var  logic [7:0]  dma_wdata,
   input  wire logic [7:0]  dma_rdata,
   input  wire logic        dma_rvalid
);
   byte_type buf_mem [0:255];   // stands in for the buffer memory

   // bus idle at time zero
   initial
   begin
      {dma_req, dma_we, dma_addr, dma_wdata} = '0;
   end

   // ==========================================================
   // single byte transfers
   task automatic wr(input logic [15:0] a, input byte_type d);
      @(negedge sys_clk);
      {dma_req, dma_we, dma_addr, dma_wdata} = {1'b1, 1'b1, a, d};
      @(negedge sys_clk);
      dma_req   = 1'b0;
      dma_wdata = ~d;   // no stale data left on the bus
   endtask : wr

   task automatic rd(input logic [15:0] a, output byte_type d);
      @(negedge sys_clk);
      {dma_req, dma_we, dma_addr} = {1'b1, 1'b0, a};
      @(negedge sys_clk);
      dma_req = 1'b0;
      d = 'x;
      for (int i = 0; i < 3; i++)
      begin
         @(negedge sys_clk);
         if (dma_rvalid === 1'b1)
         begin
            d = dma_rdata;
            break;
         end
      end
   endtask : rd

   // ==========================================================
   // staged copy in and out
   task automatic copy_in(input byte_type src, input logic [15:0] dst, input int n, input int stall);
      for (int i = 0; i < n; i++)
      begin
         wr(dst + 16'(i), buf_mem[src + 8'(i)]);
         repeat (stall) @(negedge sys_clk);
      end
   endtask : copy_in

   task automatic copy_out(input logic [15:0] src, input byte_type dst, input int n);
      byte_type d;
      for (int i = 0; i < n; i++)
      begin
         rd(src + 16'(i), d);
         buf_mem[dst + 8'(i)] = d;
      end
   endtask : copy_out
endmodule : dma_model

`default_nettype wire
